/* File: eeslv_core.sv */
// eeslv_core: two-wire eeprom slave front end, control byte and word address.
// assumes scl is a free clock port from the bus master; strap pins are static.
`default_nettype none

module eeslv_core
  import eeslv_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = TWC_CYCLES,
  parameter logic [3:0]  DEV_TYPE     = DEV_TYPE_DEFAULT
) (
  // core clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  // serial bus
  input  wire logic              scl_clk_i,
  input  wire logic              sda_i,
  output var  logic              sda_o,
  output var  logic              sda_oe_o,
  // straps
  input  wire logic              chip_select_low_pin_i,
  input  wire logic              chip_select_high_pin_i,
  input  wire logic              wp_i,
  // array side
  input  wire logic [7:0]        rd_byte_i,
  output var  logic [ADDR_W-1:0] word_addr_o,
  output var  logic              read_mode_o,
  output var  logic              selected_o,
  output var  logic [7:0]        wr_data_o,
  output var  logic              wr_data_valid_o,
  output var  logic              write_busy_o,
  output var  logic              write_commit_o
);

  // control byte decode, shared by the state machine and its checks
  function automatic logic ctrl_match(input logic [7:0] b, input logic [3:0] ty,
                                      input logic hi, input logic lo);
    ctrl_match = (b[7:CB_TYPE] == ty) && (b[CB_CS_HI] == hi) && (b[CB_CS_LO] == lo);
  endfunction : ctrl_match

  logic               link_bit_r;
  logic [5:0]         sy1_r;
  logic [5:0]         sy2_r;
  logic               scl_q_r;
  logic               sda_q_r;
  logic               bit_ev_r;
  eeslv_state_t       st_r;
  logic [2:0]         bit_cnt_r;
  logic [7:0]         shift_r;
  logic [7:0]         tx_r;
  logic [1:0]         idx_r;
  logic               ack_on_r;
  logic [7:0]         ctrl_r;
  logic [7:0]         busy_ctrl_r;
  logic               pending_r;
  logic [WC_W-1:0]    wc_cnt_r;
  logic               scl_s;
  logic               sda_s;
  logic               cap_s;
  logic               cs_hi_s;
  logic               cs_lo_s;
  logic               wp_s;
  logic               start_ev;
  logic               stop_ev;
  logic               rise_ev;
  logic               fall_ev;
  logic [7:0]         rx_byte;
  logic               byte_done;
  logic               poll_hit;
  logic               accept;

  // link side: take the data bit on the serial clock's rising edge
  always_ff @(posedge scl_clk_i)
  begin
    link_bit_r <= sda_i;
  end

  // two-stage synchronisers for every signal from outside the core clock
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      sy1_r <= SYNC_RST;
      sy2_r <= SYNC_RST;
    end
    else
    begin
      sy1_r <= {wp_i, chip_select_low_pin_i, chip_select_high_pin_i,
                link_bit_r, sda_i, scl_clk_i};
      sy2_r <= sy1_r;
    end
  end

  assign scl_s   = sy2_r[0];
  assign sda_s   = sy2_r[1];
  assign cap_s   = sy2_r[2];
  assign cs_hi_s = sy2_r[3];
  assign cs_lo_s = sy2_r[4];
  assign wp_s    = sy2_r[5];

  // previous line levels for edge and framing detection
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      scl_q_r  <= 1'b1;
      sda_q_r  <= 1'b1;
      bit_ev_r <= 1'b0;
    end
    else
    begin
      scl_q_r  <= scl_s;
      sda_q_r  <= sda_s;
      // one cycle late so the captured bit has passed its synchroniser too
      bit_ev_r <= rise_ev;
    end
  end

  assign rise_ev  = scl_s && !scl_q_r;
  assign fall_ev  = !scl_s && scl_q_r;
  assign start_ev = scl_s && scl_q_r && sda_q_r && !sda_s;
  assign stop_ev  = scl_s && scl_q_r && !sda_q_r && sda_s;

  assign rx_byte   = {shift_r[6:0], cap_s};
  assign byte_done = (st_r == ST_RECV) && bit_ev_r && (bit_cnt_r == BIT_LAST);
  assign poll_hit  = write_busy_o && (rx_byte == busy_ctrl_r);
  // only the control byte can be refused; later bytes are always taken
  assign accept    = (idx_r != IDX_CTRL) ||
                     (ctrl_match(rx_byte, DEV_TYPE, cs_hi_s, cs_lo_s) && !poll_hit);

  // frame state machine and data line drive
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      st_r      <= ST_IDLE;
      bit_cnt_r <= BIT_FIRST;
      shift_r   <= 8'h00;
      tx_r      <= 8'h00;
      idx_r     <= IDX_CTRL;
      ack_on_r  <= 1'b0;
      sda_oe_o  <= 1'b0;
    end
    else if (start_ev)
    begin
      st_r      <= ST_RECV;
      bit_cnt_r <= BIT_FIRST;
      idx_r     <= IDX_CTRL;
      ack_on_r  <= 1'b0;
      sda_oe_o  <= 1'b0;
    end
    else if (stop_ev)
    begin
      st_r     <= ST_IDLE;
      ack_on_r <= 1'b0;
      sda_oe_o <= 1'b0;
    end
    else
    begin
      case (st_r)
        ST_RECV:
          if (bit_ev_r)
          begin
            shift_r   <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == BIT_LAST)
            begin
              st_r <= accept ? ST_ACK : ST_IGNORE;
              if (accept && idx_r != IDX_DATA)
                idx_r <= idx_r + 2'h1;
            end
          end
        ST_ACK:
          if (fall_ev)
          begin
            if (!ack_on_r)
            begin
              sda_oe_o <= 1'b1;
              ack_on_r <= 1'b1;
            end
            else
            begin
              ack_on_r <= 1'b0;
              if (read_mode_o)
              begin
                sda_oe_o  <= !rd_byte_i[7];
                tx_r      <= {rd_byte_i[6:0], 1'b0};
                bit_cnt_r <= BIT_SECOND;
                st_r      <= ST_SEND;
              end
              else
              begin
                sda_oe_o  <= 1'b0;
                bit_cnt_r <= BIT_FIRST;
                st_r      <= ST_RECV;
              end
            end
          end
        ST_SEND:
          if (fall_ev)
          begin
            if (bit_cnt_r == BIT_FIRST)
            begin
              sda_oe_o <= 1'b0; // release for the master's acknowledge
              st_r     <= ST_MACK;
            end
            else
            begin
              sda_oe_o  <= !tx_r[7];
              tx_r      <= {tx_r[6:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 3'h1;
            end
          end
        ST_MACK:
          if (bit_ev_r)
            st_r <= cap_s ? ST_IGNORE : ST_RELOAD;
        ST_RELOAD:
          if (fall_ev)
          begin
            sda_oe_o  <= !rd_byte_i[7];
            tx_r      <= {rd_byte_i[6:0], 1'b0};
            bit_cnt_r <= BIT_SECOND;
            st_r      <= ST_SEND;
          end
        default:
          st_r <= st_r; // idle or ignoring: wait for a start
      endcase
    end
  end

  // control byte, word address and received data
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ctrl_r          <= 8'h00;
      word_addr_o     <= '0;
      read_mode_o     <= 1'b0;
      selected_o      <= 1'b0;
      wr_data_o       <= 8'h00;
      wr_data_valid_o <= 1'b0;
      pending_r       <= 1'b0;
      sda_o           <= 1'b0;
    end
    else
    begin
      sda_o           <= 1'b0;
      wr_data_valid_o <= byte_done && accept && (idx_r == IDX_DATA);
      if (start_ev || stop_ev)
      begin
        selected_o <= 1'b0;
        pending_r  <= 1'b0; // a repeated start abandons buffered data
      end
      else if (byte_done && accept)
      begin
        case (idx_r)
          IDX_CTRL:
          begin
            ctrl_r               <= rx_byte;
            selected_o           <= 1'b1;
            word_addr_o[SEG_BIT] <= rx_byte[CB_SEG];
            read_mode_o          <= rx_byte[CB_RW];
          end
          IDX_ADDR_HI:
            word_addr_o[15:8] <= rx_byte;
          IDX_ADDR_LO:
            word_addr_o[7:0] <= rx_byte;
          default:
          begin
            wr_data_o                    <= rx_byte;
            pending_r                    <= 1'b1;
            // page writes wrap inside the page
            word_addr_o[PAGE_BITS-1:0] <= word_addr_o[PAGE_BITS-1:0] + 7'h01;
          end
        endcase
      end
      else if (st_r == ST_MACK && bit_ev_r)
      begin
        // segment bit is left alone so reads wrap inside their half
        word_addr_o[SEG_BIT-1:0] <= word_addr_o[SEG_BIT-1:0] + 16'h0001;
      end
    end
  end

  // internal write cycle timer, started by the stop of a write
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      write_busy_o   <= 1'b0;
      write_commit_o <= 1'b0;
      wc_cnt_r       <= '0;
      busy_ctrl_r    <= 8'h00;
    end
    else
    begin
      // protect is sampled only here; later changes do not matter
      write_commit_o <= stop_ev && pending_r && !wp_s;
      if (stop_ev && pending_r && !wp_s)
      begin
        write_busy_o <= 1'b1;
        wc_cnt_r     <= '0;
        busy_ctrl_r  <= ctrl_r;
      end
      else if (write_busy_o)
      begin
        if (wc_cnt_r == WC_W'(WRITE_CYCLES - 1))
          write_busy_o <= 1'b0;
        else
          wc_cnt_r <= wc_cnt_r + WC_W'(1);
      end
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_ack_begin;
    st_r == ST_ACK && fall_ev && !ack_on_r;
  endsequence
  sequence s_nack_seen;
    st_r == ST_MACK && bit_ev_r && cap_s;
  endsequence

  chk_oe_clock_low: assert property (
    $changed(sda_oe_o) |-> $past(fall_ev) || $past(start_ev) || $past(stop_ev))
    else $error("data line drive changed outside serial clock low");
  chk_sel_match: assert property (
    $rose(selected_o) |-> ctrl_match($past(rx_byte), DEV_TYPE, $past(cs_hi_s), $past(cs_lo_s)))
    else $error("selected without a matching control byte");
  chk_poll_block: assert property (
    byte_done && idx_r == IDX_CTRL && write_busy_o && rx_byte == busy_ctrl_r
    |=> st_r == ST_IGNORE && !selected_o)
    else $error("poll acknowledged during write cycle");
  chk_ack_hold: assert property (
    s_ack_begin |=> sda_oe_o [*4])
    else $error("acknowledge not held low");
  chk_ignore_quiet: assert property (
    st_r == ST_IGNORE |-> !sda_oe_o)
    else $error("data line driven while ignoring");
  chk_nack_release: assert property (
    s_nack_seen |=> st_r == ST_IGNORE ##0 !sda_oe_o [*3])
    else $error("line not released after master nack");
  chk_wp_inhibit: assert property (
    stop_ev && pending_r && wp_s |=> !write_commit_o && write_busy_o == $past(write_busy_o))
    else $error("write cycle started while protected");
  chk_busy_len: assert property (
    write_busy_o |-> wc_cnt_r < WC_W'(WRITE_CYCLES))
    else $error("write cycle ran too long");
  chk_seg_hold: assert property (
    $changed(word_addr_o[SEG_BIT]) |-> $past(byte_done) && $past(idx_r) == IDX_CTRL)
    else $error("segment bit changed outside control byte");
  chk_dir_decode: assert property (
    $rose(selected_o) |-> read_mode_o == $past(rx_byte[CB_RW]))
    else $error("direction not taken from last control bit");
  chk_addr_order: assert property (
    byte_done && accept && idx_r == IDX_ADDR_HI |=> word_addr_o[15:8] == $past(rx_byte))
    else $error("high address byte not stored first");
  chk_start_frame: assert property (
    start_ev |=> st_r == ST_RECV && bit_cnt_r == BIT_FIRST && !sda_oe_o)
    else $error("start did not open a frame");
  chk_stop_idle: assert property (
    stop_ev |=> st_r == ST_IDLE && !selected_o)
    else $error("stop did not end the frame");
  chk_one_bit: assert property (
    st_r == ST_RECV && bit_ev_r && !start_ev && !stop_ev && bit_cnt_r != BIT_LAST
    |=> bit_cnt_r == 3'($past(bit_cnt_r) + 3'h1))
    else $error("bit count not one per clock pulse");
  chk_open_drain: assert property (
    !sda_o)
    else $error("data line driven high");

endmodule : eeslv_core

`default_nettype wire

/* File: eeslv_master_model.sv */
// eeslv_master_model: behavioural two-wire bus master for the eeprom slave.
// assumes an external pull-up: the line reads high unless a party pulls it low.
`default_nettype none

module eeslv_master_model (
  // resolved data line
  input  wire logic sda_i,
  // serial clock and open-drain pull
  output var  logic scl_o,
  output var  logic sda_low_o
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF = 32;
  localparam int QTR  = 16;

  // idle bus: clock stands high between frames, data released
  initial
  begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // start from idle or as a repeated start; the 7 ns lead keeps clock edges off core edges
  task automatic bus_start();
    if (scl_o === 1'b1)
      #7;
    else
    begin
      #QTR sda_low_o = 1'b0;
      #QTR scl_o = 1'b1;
      #QTR;
    end
    sda_low_o = 1'b1;
    #HALF scl_o = 1'b0;
  endtask : bus_start

  // data moves only at mid-low; line sampled at mid-high
  task automatic put_bit(input logic b, output logic s);
    #QTR sda_low_o = ~b;
    #QTR scl_o = 1'b1;
    #QTR s = sda_i;
    #QTR scl_o = 1'b0;
  endtask : put_bit

  // eight bits msb first, then a released ninth pulse for the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte

  // last byte of a read is left unacknowledged by the caller
  task automatic recv_byte(input logic give_ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(1'b1, d[i]);
    put_bit(~give_ack, s);
  endtask : recv_byte

  // data rises while clock high
  task automatic bus_stop();
    #QTR sda_low_o = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR sda_low_o = 1'b0;
    #HALF;
  endtask : bus_stop

endmodule : eeslv_master_model

`default_nettype wire

/* File: eeslv_pkg.sv */
// eeslv_pkg: constants and types for the two-wire eeprom slave front end.
// assumes a 125 MHz core clock; the serial clock arrives as its own clock.
`default_nettype none

package eeslv_pkg;

  // core clock rate and internal write cycle time
  localparam int unsigned CORE_CLK_HZ = 125_000_000;
  localparam int unsigned TWC_MS      = 5;
  // longest time, so the cycle count rounds down
  localparam int unsigned TWC_CYCLES  = TWC_MS * (CORE_CLK_HZ / 1000);
  localparam int unsigned WC_W        = 20;

  // device type code; this value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;

  // control byte field positions
  localparam int unsigned CB_RW    = 0;
  localparam int unsigned CB_SEG   = 1;
  localparam int unsigned CB_CS_LO = 2;
  localparam int unsigned CB_CS_HI = 3;
  localparam int unsigned CB_TYPE  = 4;

  // word address layout
  localparam int unsigned ADDR_W    = 17;
  localparam int unsigned SEG_BIT   = 16;
  localparam int unsigned PAGE_BITS = 7;

  // bit counter and byte index within a frame
  localparam logic [2:0] BIT_FIRST   = 3'h0;
  localparam logic [2:0] BIT_SECOND  = 3'h1;
  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam logic [1:0] IDX_CTRL    = 2'h0;
  localparam logic [1:0] IDX_ADDR_HI = 2'h1;
  localparam logic [1:0] IDX_ADDR_LO = 2'h2;
  localparam logic [1:0] IDX_DATA    = 2'h3;

  // synchroniser reset: idle bus lines are high
  localparam logic [5:0] SYNC_RST = 6'h3F;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK, ST_RELOAD, ST_IGNORE
  } eeslv_state_t;

endpackage : eeslv_pkg

`default_nettype wire

/* File: tb.sv */
// tb: self-checking bench for eeslv_core with a behavioural bus master.
// assumes the master model owns the serial clock; straps change only between frames.
`default_nettype none

module tb
  import eeslv_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned WCYC = 200;
  localparam logic [1:0]  CS   = 2'b10;

  logic        core_clk;
  logic        srst;
  logic        cs_lo;
  logic        cs_hi;
  logic        wp;
  logic [7:0]  rd_byte = 8'h00;
  wire logic   scl;
  wire logic   sda;
  wire logic   m_low;
  logic        sda_o;
  logic        sda_oe;
  logic [16:0] word_addr;
  logic        read_mode;
  logic        selected;
  logic [7:0]  wr_data;
  logic        wr_valid;
  logic        busy;
  logic        commit;
  int          compares   = 0;
  int          mismatches = 0;
  int          busy_cyc   = 0;
  int          commit_cnt = 0;
  int          valid_cnt  = 0;

  // open-drain wire with pull-up
  assign sda = (sda_oe || m_low) ? 1'b0 : 1'b1;

  eeslv_core #(.WRITE_CYCLES(WCYC)) u_eeslv_core (
    .core_clk_i(core_clk), .srst_i(srst), .scl_clk_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .chip_select_low_pin_i(cs_lo),
    .chip_select_high_pin_i(cs_hi), .wp_i(wp), .rd_byte_i(rd_byte),
    .word_addr_o(word_addr), .read_mode_o(read_mode), .selected_o(selected),
    .wr_data_o(wr_data), .wr_data_valid_o(wr_valid), .write_busy_o(busy),
    .write_commit_o(commit));

  eeslv_master_model u_eeslv_master_model (.sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // busy length, commit and data strobes are counted rather than polled, so no pulse is missed
  always @(posedge core_clk)
  begin
    if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
    if (commit === 1'b1) commit_cnt <= commit_cnt + 1;
    if (wr_valid === 1'b1) valid_cnt <= valid_cnt + 1;
  end

  // array model: data is a fixed function of the address
  always @(negedge core_clk) rd_byte <= word_addr[7:0] ^ 8'h3C;

  // the device may only move its pull while the clock is low
  always @(sda_oe) if (srst === 1'b0) check(scl, 1'b0);

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic open_frame();
    @(negedge core_clk);
    u_eeslv_master_model.bus_start();
  endtask : open_frame

  task automatic tx(input logic [7:0] b, input logic exp_ack);
    logic a;
    u_eeslv_master_model.send_byte(b, a);
    check(a, exp_ack);
  endtask : tx

  task automatic wait_ready();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 2000)
    begin
      mismatches++;
      print_verdict();
    end
  endtask : wait_ready

  // every strap pair against every chip-select field, plus a wrong type code
  task automatic sc_select();
    logic ok;
    for (int j = 0; j < 4; j++)
    begin
      @(negedge core_clk) {cs_hi, cs_lo} = 2'(j);
      for (int i = 0; i < 4; i++)
      begin
        ok = (i == j);
        open_frame();
        tx({DEV_TYPE_DEFAULT, 2'(i), 2'b00}, ok);
        check(selected, ok);
        tx(8'h00, ok);
        u_eeslv_master_model.bus_stop();
      end
    end
    @(negedge core_clk) {cs_hi, cs_lo} = CS;
    open_frame();
    tx({~DEV_TYPE_DEFAULT, CS, 2'b00}, 1'b0);
    u_eeslv_master_model.bus_stop();
  endtask : sc_select

  // page write crossing the page end, busy poll, write-protect toggled mid-cycle
  task automatic sc_write();
    int b0;
    int c0;
    int v0;
    v0 = valid_cnt;
    open_frame();
    tx({DEV_TYPE_DEFAULT, CS, 2'b00}, 1'b1);
    check(read_mode, 1'b0);
    check(sda_o, 1'b0);
    tx(8'h12, 1'b1);
    tx(8'hFF, 1'b1);
    check(word_addr, 17'h012FF);
    tx(8'h5A, 1'b1);
    check(wr_data, 17'h5A);
    tx(8'h6B, 1'b1);
    check(wr_data, 17'h6B);
    check(17'(valid_cnt - v0), 17'h2);
    check(word_addr, 17'h01281);
    c0 = commit_cnt;
    b0 = busy_cyc;
    u_eeslv_master_model.bus_stop();
    @(negedge core_clk) wp = 1'b1;
    check(17'(commit_cnt - c0), 17'h1);
    check(selected, 1'b0);
    open_frame();
    tx({DEV_TYPE_DEFAULT, CS, 2'b00}, 1'b0);
    u_eeslv_master_model.bus_stop();
    wait_ready();
    check(17'(busy_cyc - b0), 17'(WCYC));
    @(negedge core_clk) wp = 1'b0;
    open_frame();
    tx({DEV_TYPE_DEFAULT, CS, 2'b00}, 1'b1);
    u_eeslv_master_model.bus_stop();
    check(17'(commit_cnt - c0), 17'h1);
  endtask : sc_write

  // protected write is acknowledged, starts nothing, next command taken at once
  task automatic sc_wp();
    int c0;
    @(negedge core_clk) wp = 1'b1;
    c0 = commit_cnt;
    open_frame();
    tx({DEV_TYPE_DEFAULT, CS, 2'b00}, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h10, 1'b1);
    tx(8'hC3, 1'b1);
    u_eeslv_master_model.bus_stop();
    check(17'(commit_cnt - c0), 17'h0);
    check(busy, 1'b0);
    open_frame();
    tx({DEV_TYPE_DEFAULT, CS, 2'b00}, 1'b1);
    u_eeslv_master_model.bus_stop();
    @(negedge core_clk) wp = 1'b0;
  endtask : sc_wp

  // random read at the top of the upper segment; sequential read wraps inside it
  task automatic sc_read();
    logic [7:0] d;
    int         c0;
    c0 = commit_cnt;
    open_frame();
    tx({DEV_TYPE_DEFAULT, CS, 2'b10}, 1'b1);
    tx(8'hFF, 1'b1);
    tx(8'hFF, 1'b1);
    check(word_addr, 17'h1FFFF);
    u_eeslv_master_model.bus_start();
    tx({DEV_TYPE_DEFAULT, CS, 2'b11}, 1'b1);
    check(read_mode, 1'b1);
    u_eeslv_master_model.recv_byte(1'b1, d);
    check(d, 17'hC3);
    u_eeslv_master_model.recv_byte(1'b0, d);
    check(d, 17'h3C);
    check(word_addr, 17'h10001);
    check(sda_oe, 1'b0);
    u_eeslv_master_model.bus_stop();
    check(17'(commit_cnt - c0), 17'h0);
  endtask : sc_read

  initial
  begin
    srst  = 1'b1;
    {cs_hi, cs_lo} = CS;
    wp    = 1'b0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk) srst = 1'b0;
    repeat (4) @(negedge core_clk);
    check(sda_oe, 1'b0);
    check(busy, 1'b0);
    sc_select();
    sc_write();
    sc_wp();
    sc_read();
    print_verdict();
  end

endmodule : tb

`default_nettype wire
